// ---- rtl/pci_map.svh ----
// Constants for the positioning command input decoder
`ifndef PCI_MAP_SVH
`define PCI_MAP_SVH
`define PCI_POS_W          32
`define PCI_MODE_POSITION  4'h3
`define PCI_PASSIVE_SET    2'h0
`define PCI_PASSIVE_MOVE   2'h2
`define PCI_EBC_SLOW_MIN   3'h2
`define PCI_FSTOP_ON       1'h1
`endif

// ---- rtl/pci_pkg.sv ----
// Types for the positioning command input decoder
package pci_pkg;
	// Command inputs, terminal or fieldbus levels
	typedef struct packed {
		logic teach_request_bit;
		logic homing_start_bit;
		logic ext_block_change_bit;
		logic fixed_stop_sensor_bit;
		logic passive_homing_bit;
		logic tracking_select_bit;
		logic set_reference_bit;
	} pci_cmd_t;

	// Block change input sources
	typedef struct packed {
		logic fast_input_terminal;
		logic slow_input_one;
		logic slow_input_two;
		logic fast_is_ebc;
	} pci_ebc_src_t;
endpackage : pci_pkg

// ---- rtl/pci_edge.sv ----
// Two-flop synchroniser with single-pulse edge detection
`timescale 1ns/1ps
`default_nettype none
module pci_edge
(
	input  wire logic sys_clk_i,  // System clock
	input  wire logic rst_n_i,    // Sync reset, low active
	input  wire logic din_i,      // Asynchronous level
	output logic      level_o,    // Synchronised level
	output logic      rise_o,     // One-cycle rising pulse
	output logic      fall_o      // One-cycle falling pulse
);
	logic meta;
	logic sync;
	logic prev;

	// Synchroniser and previous-value register
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			meta <= 1'h0;
			sync <= 1'h0;
			prev <= 1'h0;
		end
		else
		begin
			meta <= din_i;
			sync <= meta;
			prev <= sync;
		end
	end

	assign level_o = sync;
	assign rise_o  = sync & ~prev;
	assign fall_o  = ~sync & prev;
endmodule : pci_edge
`default_nettype wire

// ---- rtl/pci_top.sv ----
// Positioning command input decoder, main module
`timescale 1ns/1ps
`default_nettype none
`include "pci_map.svh"
module pci_top
	import pci_pkg::*;
(
	input  wire logic                   sys_clk_i,         // 20 MHz clock
	input  wire logic                   rst_n_i,           // Sync reset, low active
	input  wire pci_cmd_t               cmd_i,             // Command levels
	input  wire pci_ebc_src_t           ebc_src_i,         // Block change sources
	input  wire logic                   controller_enable_i, // Controller enable
	input  wire logic [3:0]             operating_mode_setting_i, // Mode setting
	input  wire logic [2:0]             ext_block_change_config_i, // Missing edge cfg
	input  wire logic                   fixed_stop_config_two_i, // Fixed-stop cfg
	input  wire logic [1:0]             passive_homing_mode_i, // Passive mode
	input  wire logic [`PCI_POS_W-1:0]  reference_coordinate_i, // Reference value
	input  wire logic                   actual_invert_a_i, // Inversion setting a
	input  wire logic                   actual_invert_b_i, // Inversion setting b
	input  wire logic                   actual_invert_c_i, // Inversion setting c
	input  wire logic [`PCI_POS_W-1:0]  axis_position_i,   // Axis actual position
	input  wire logic                   moving_positive_i, // Raw travel direction
	input  wire logic                   block_running_i,   // Block executing
	input  wire logic                   block_ext_cont_i,  // Block advance external
	input  wire logic                   block_flying_i,    // Block advance flying
	input  wire logic                   brake_too_long_i,  // Brake distance too big
	input  wire logic                   zero_mark_found_i, // Zero mark seen
	input  wire logic                   error_tracking_i,  // Error reaction tracking
	input  wire logic                   homing_done_i,     // Approach completed
	input  wire logic                   teach_done_i,      // Teach write confirmed
	output logic                        teach_write_o,     // Teach write pulse
	output logic [`PCI_POS_W-1:0]       teach_position_o,  // Teach target value
	output logic                        teach_ok_o,        // Teach succeeded
	output logic                        homing_active_o,   // Approach running
	output logic                        brake_max_o,       // Brake at max decel
	output logic                        reference_set_o,   // Axis referenced
	output logic                        block_change_o,    // External change pulse
	output logic [`PCI_POS_W-1:0]       block_change_position_o, // Latched position
	output logic                        advance_with_stop_o, // Downgraded advance
	output logic                        ebc_missing_mode_o, // Wait-on-missing edge
	output logic                        fixed_stop_reached_o, // Fixed stop reached
	output logic                        passive_search_o,  // Cam/zero search
	output logic                        passive_move_o,    // Move through deviation
	output logic                        passive_fault_o,   // Zero mark missing
	output logic                        position_loop_open_o, // Loop open
	output logic                        setpoint_enable_o, // Setpoint output on
	output logic                        follow_error_mask_o, // Error suppression
	output logic                        tracking_active_o, // Tracking state
	output logic [`PCI_POS_W-1:0]       actual_load_value_o, // Position to load
	output logic                        actual_load_o      // Position load pulse
);
	//--------------------------------------------------
	// Input edge detection
	//--------------------------------------------------
	logic [9:0] raw;
	logic [9:0] lvl;
	logic [9:0] rise;
	logic [9:0] fall;

	assign raw = {cmd_i.teach_request_bit, cmd_i.homing_start_bit,
		cmd_i.ext_block_change_bit, cmd_i.fixed_stop_sensor_bit,
		cmd_i.passive_homing_bit, cmd_i.tracking_select_bit,
		cmd_i.set_reference_bit, ebc_src_i.fast_input_terminal,
		ebc_src_i.slow_input_one, ebc_src_i.slow_input_two};

	genvar gi;
	generate
		for (gi = 0; gi < 10; gi++)
		begin : g_edge
			pci_edge u_edge
			(
				.sys_clk_i (sys_clk_i),
				.rst_n_i   (rst_n_i),
				.din_i     (raw[gi]),
				.level_o   (lvl[gi]),
				.rise_o    (rise[gi]),
				.fall_o    (fall[gi])
			);
		end
	endgenerate

	// Index names of the synchronised inputs
	localparam int TEACH = 9;
	localparam int HOME  = 8;
	localparam int EBCB  = 7;
	localparam int FSTOP = 6;
	localparam int PASV  = 5;
	localparam int TRACK = 4;
	localparam int SETR  = 3;
	localparam int FAST  = 2;
	localparam int SLOW1 = 1;
	localparam int SLOW2 = 0;

	// Level-input synchronisers for controller enable and travel direction
	logic en_m, en_s, dir_m, dir_s;
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			en_m  <= 1'h0;
			en_s  <= 1'h0;
			dir_m <= 1'h0;
			dir_s <= 1'h0;
		end
		else
		begin
			en_m  <= controller_enable_i;
			en_s  <= en_m;
			dir_m <= moving_positive_i;
			dir_s <= dir_m;
		end
	end

	//--------------------------------------------------
	// Direction sense and block change source select
	//--------------------------------------------------
	// Odd parity of inversion settings inverts sense
	function automatic logic dir_positive(input logic raw_dir, input logic a,
		input logic b, input logic c);
		dir_positive = raw_dir ^ (a ^ b ^ c);
	endfunction : dir_positive

	logic positive;
	logic fast_evt;
	logic slow_evt;
	logic ebc_evt;

	assign positive = dir_positive(dir_s, actual_invert_a_i, actual_invert_b_i,
		actual_invert_c_i);
	// Falling edge when positive, rising when negative
	assign fast_evt = positive ? fall[FAST] : rise[FAST];
	// Slow terminals and fieldbus bit take any edge
	assign slow_evt = rise[SLOW1] | fall[SLOW1] | rise[SLOW2] | fall[SLOW2]
		| rise[EBCB] | fall[EBCB];
	// Fast assignment masks every other source
	assign ebc_evt = ebc_src_i.fast_is_ebc ? fast_evt : slow_evt;

	//--------------------------------------------------
	// External block change
	//--------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			block_change_o          <= 1'h0;
			block_change_position_o <= '0;
			advance_with_stop_o     <= 1'h0;
		end
		else
		begin
			block_change_o <= ebc_evt & block_ext_cont_i & block_running_i;
			if (ebc_evt & block_ext_cont_i & block_running_i)
				block_change_position_o <= axis_position_i;
			advance_with_stop_o <= block_flying_i & brake_too_long_i;
		end
	end

	// Config at or above the slow threshold selects the missing-edge reaction
	assign ebc_missing_mode_o = (ext_block_change_config_i >= `PCI_EBC_SLOW_MIN);

	//--------------------------------------------------
	// Teach-in
	//--------------------------------------------------
	logic teach_ok_cond;
	assign teach_ok_cond = (operating_mode_setting_i == `PCI_MODE_POSITION)
		& ~block_running_i & reference_set_o;

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			teach_write_o    <= 1'h0;
			teach_position_o <= '0;
			teach_ok_o       <= 1'h0;
		end
		else
		begin
			teach_write_o <= fall[TEACH] & teach_ok_cond;
			if (fall[TEACH] & teach_ok_cond)
				teach_position_o <= axis_position_i;
			// Confirmation wins over a coinciding clear
			if (teach_done_i)
				teach_ok_o <= 1'h1;
			else if (fall[TEACH])
				teach_ok_o <= 1'h0;
		end
	end

	//--------------------------------------------------
	// Reference approach and reference point
	//--------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			homing_active_o <= 1'h0;
			brake_max_o     <= 1'h0;
			reference_set_o <= 1'h0;
		end
		else
		begin
			brake_max_o <= 1'h0;
			if (rise[HOME])
			begin
				homing_active_o <= 1'h1;
				reference_set_o <= 1'h0;
			end
			else if (fall[HOME] & homing_active_o)
			begin
				homing_active_o <= 1'h0;
				brake_max_o     <= 1'h1;
			end
			else if (homing_done_i & homing_active_o)
			begin
				homing_active_o <= 1'h0;
				reference_set_o <= 1'h1;
			end
			if (actual_load_o)
				reference_set_o <= 1'h1;
		end
	end

	//--------------------------------------------------
	// Passive referencing and set reference point
	//--------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			passive_search_o    <= 1'h0;
			passive_move_o      <= 1'h0;
			passive_fault_o     <= 1'h0;
			actual_load_o       <= 1'h0;
			actual_load_value_o <= '0;
		end
		else
		begin
			actual_load_o  <= 1'h0;
			passive_move_o <= 1'h0;
			if (rise[PASV])
			begin
				passive_search_o <= 1'h1;
				passive_fault_o  <= 1'h0;
			end
			else if (fall[PASV])
			begin
				passive_search_o <= 1'h0;
				if (passive_search_o & ~zero_mark_found_i)
					passive_fault_o <= 1'h1;
				else if (passive_homing_mode_i == `PCI_PASSIVE_SET)
				begin
					actual_load_o       <= 1'h1;
					actual_load_value_o <= reference_coordinate_i;
				end
				else if (passive_homing_mode_i == `PCI_PASSIVE_MOVE)
					passive_move_o <= 1'h1;
			end
			if (rise[SETR] & ~block_running_i)
			begin
				actual_load_o       <= 1'h1;
				actual_load_value_o <= reference_coordinate_i;
			end
		end
	end

	//--------------------------------------------------
	// Fixed stop and tracking mode
	//--------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			fixed_stop_reached_o <= 1'h0;
			tracking_active_o    <= 1'h0;
		end
		else
		begin
			fixed_stop_reached_o <= lvl[FSTOP]
				& (fixed_stop_config_two_i == `PCI_FSTOP_ON);
			if ((lvl[TRACK] & ~en_s) | error_tracking_i)
				tracking_active_o <= 1'h1;
			else if (~lvl[TRACK] & en_s)
				tracking_active_o <= 1'h0;
		end
	end

	// Loop open, no setpoint, errors masked while tracking
	assign position_loop_open_o = tracking_active_o;
	assign setpoint_enable_o    = ~tracking_active_o;
	assign follow_error_mask_o  = tracking_active_o;
endmodule : pci_top
`default_nettype wire

// ---- verification/pci_plc.sv ----
// Controller model that drives the command levels
`timescale 1ns/1ps
`default_nettype none
module pci_plc
	import pci_pkg::*;
(
	input  wire logic         sys_clk_i, // Clock
	output var  pci_cmd_t     cmd_o,     // Command levels
	output var  pci_ebc_src_t src_o      // Block change sources
);
	// ----------------------------------------
	// Level driver
	// ----------------------------------------
	initial
	begin
		cmd_o = '0;
		src_o = '0;
	end
	// New levels just after the edge
	task automatic put(input pci_cmd_t c, input pci_ebc_src_t s);
	begin
		@(posedge sys_clk_i);
		#2;
		cmd_o = c; // Command levels applied as given
		src_o = s;
	end
	endtask : put
endmodule : pci_plc
`default_nettype wire

// ---- verification/pci_top_chk.sv ----
// Concurrent checks on the decoder ports
`timescale 1ns/1ps
`default_nettype none
`include "pci_map.svh"
module pci_top_chk
(
	input wire logic                  sys_clk_i,                 // Clock
	input wire logic                  rst_n_i,                   // Reset
	input wire logic [3:0]            operating_mode_setting_i,  // Mode
	input wire logic [2:0]            ext_block_change_config_i, // Cfg
	input wire logic                  fixed_stop_config_two_i,   // Cfg
	input wire logic [`PCI_POS_W-1:0] reference_coordinate_i,    // Ref
	input wire logic                  block_running_i,           // Busy
	input wire logic                  block_ext_cont_i,          // Ext
	input wire logic                  error_tracking_i,          // Err
	input wire logic                  teach_write_o,             // Out
	input wire logic                  reference_set_o,           // Out
	input wire logic                  brake_max_o,               // Out
	input wire logic                  block_change_o,            // Out
	input wire logic                  ebc_missing_mode_o,        // Out
	input wire logic                  fixed_stop_reached_o,      // Out
	input wire logic                  position_loop_open_o,      // Out
	input wire logic                  setpoint_enable_o,         // Out
	input wire logic                  follow_error_mask_o,       // Out
	input wire logic                  tracking_active_o,         // Out
	input wire logic [`PCI_POS_W-1:0] actual_load_value_o,       // Out
	input wire logic                  actual_load_o              // Out
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Single pulse shape
	sequence s_single;
		block_change_o ##1 !block_change_o;
	endsequence
	chk_teach_gate: assert property (teach_write_o |-> $past(reference_set_o) &&
		!$past(block_running_i) &&
		$past(operating_mode_setting_i) == `PCI_MODE_POSITION) else $error("teach gate");
	chk_teach_pulse: assert property (teach_write_o |=> !teach_write_o)
		else $error("teach pulse");
	chk_abort_ref: assert property (brake_max_o |-> !reference_set_o)
		else $error("abort ref");
	chk_change_gate: assert property (block_change_o |->
		$past(block_running_i) && $past(block_ext_cont_i)) else $error("change gate");
	chk_change_once: assert property ($rose(block_change_o) |-> s_single)
		else $error("change pulse");
	chk_missing_cfg: assert property (ebc_missing_mode_o ==
		(ext_block_change_config_i >= `PCI_EBC_SLOW_MIN)) else $error("missing cfg");
	chk_fstop_gate: assert property (fixed_stop_reached_o |->
		$past(fixed_stop_config_two_i)) else $error("fixed stop gate");
	chk_track_loop: assert property (position_loop_open_o == tracking_active_o &&
		follow_error_mask_o == tracking_active_o && setpoint_enable_o == !tracking_active_o)
		else $error("tracking outputs");
	chk_err_track: assert property (error_tracking_i |-> ##[1:2] tracking_active_o)
		else $error("error tracking");
	chk_load_value: assert property (actual_load_o |->
		actual_load_value_o == $past(reference_coordinate_i)) else $error("load value");
endmodule : pci_top_chk
bind pci_top pci_top_chk u_chk
(
	.sys_clk_i                 (sys_clk_i),
	.rst_n_i                   (rst_n_i),
	.operating_mode_setting_i  (operating_mode_setting_i),
	.ext_block_change_config_i (ext_block_change_config_i),
	.fixed_stop_config_two_i   (fixed_stop_config_two_i),
	.reference_coordinate_i    (reference_coordinate_i),
	.block_running_i           (block_running_i),
	.block_ext_cont_i          (block_ext_cont_i),
	.error_tracking_i          (error_tracking_i),
	.teach_write_o             (teach_write_o),
	.reference_set_o           (reference_set_o),
	.brake_max_o               (brake_max_o),
	.block_change_o            (block_change_o),
	.ebc_missing_mode_o        (ebc_missing_mode_o),
	.fixed_stop_reached_o      (fixed_stop_reached_o),
	.position_loop_open_o      (position_loop_open_o),
	.setpoint_enable_o         (setpoint_enable_o),
	.follow_error_mask_o       (follow_error_mask_o),
	.tracking_active_o         (tracking_active_o),
	.actual_load_value_o       (actual_load_value_o),
	.actual_load_o             (actual_load_o)
);
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the command input decoder
`timescale 1ns/1ps
`default_nettype none
`include "pci_map.svh"
module tb import pci_pkg::*;;
	logic sys_clk_i = 0, rst_n_i = 0, controller_enable_i, moving_positive_i, block_running_i;
	logic block_ext_cont_i, block_flying_i, brake_too_long_i, zero_mark_found_i;
	logic error_tracking_i, homing_done_i, teach_done_i, fixed_stop_config_two_i;
	logic actual_invert_a_i, actual_invert_b_i, actual_invert_c_i;
	logic [3:0] operating_mode_setting_i;
	logic [2:0] ext_block_change_config_i;
	logic [1:0] passive_homing_mode_i;
	logic [31:0] reference_coordinate_i, axis_position_i;
	logic teach_write_o, teach_ok_o, homing_active_o, brake_max_o, reference_set_o;
	logic block_change_o, advance_with_stop_o, ebc_missing_mode_o, fixed_stop_reached_o;
	logic passive_search_o, passive_move_o, passive_fault_o, position_loop_open_o;
	logic setpoint_enable_o, follow_error_mask_o, tracking_active_o, actual_load_o;
	logic [31:0] teach_position_o, block_change_position_o, actual_load_value_o;
	pci_cmd_t cmd_i, c;
	pci_ebc_src_t ebc_src_i, s;
	logic [4:0] seen;
	logic [2:0] pat [4] = '{3'h0, 3'h4, 3'h6, 3'h7};
	int n_errors = 0, cmp_count = 0, nbc;
	// ----------------------------------------
	// Design, controller model, clock
	// ----------------------------------------
	pci_top DUT (.*);
	pci_plc plc (.sys_clk_i(sys_clk_i), .cmd_o(cmd_i), .src_o(ebc_src_i));
	always #25 sys_clk_i = ~sys_clk_i;
	// Compare one value
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Apply command levels
	task ap();
		plc.put(c, s);
	endtask : ap
	task tick();
		@(posedge sys_clk_i);
		#2;
	endtask : tick
	// Collect pulses over n cycles
	task watch(input int n);
		seen = '0;
		nbc = 0;
		repeat (n)
		begin
			@(posedge sys_clk_i);
			#2;
			seen |= {teach_write_o, block_change_o, actual_load_o, brake_max_o, passive_move_o};
			if (block_change_o === 1'b1) nbc++;
		end
	endtask : watch
	// Passive rise then fall
	task pas();
		c.passive_homing_bit = 1;
		ap();
		watch(6);
		chk("search", 1, passive_search_o);
		c.passive_homing_bit = 0;
		ap();
		watch(6);
	endtask : pas
	task wrap_up();
		$display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	initial
	begin
		#100000;
		n_errors++;
		wrap_up();
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		c = '0; s = '0; controller_enable_i = 1; moving_positive_i = 1; block_running_i = 1;
		block_ext_cont_i = 0; block_flying_i = 0; brake_too_long_i = 0; zero_mark_found_i = 0;
		error_tracking_i = 0; homing_done_i = 0; teach_done_i = 0; fixed_stop_config_two_i = 0;
		{actual_invert_a_i, actual_invert_b_i, actual_invert_c_i} = 3'h0;
		operating_mode_setting_i = 4'h3; ext_block_change_config_i = 3'h2;
		passive_homing_mode_i = 2'h2; reference_coordinate_i = 32'h00001234;
		axis_position_i = 32'h00000ABC;
		repeat (5) @(posedge sys_clk_i);
		#2;
		rst_n_i = 1;
		chk("missing mode", 1, ebc_missing_mode_o);
		ext_block_change_config_i = 3'h1;
		tick();
		chk("missing mode low", 0, ebc_missing_mode_o);
		ext_block_change_config_i = 3'h2;
		c.set_reference_bit = 1;
		ap();
		watch(6);
		chk("set ref busy", 0, reference_set_o);
		c.set_reference_bit = 0; block_running_i = 0;
		ap();
		watch(3);
		c.set_reference_bit = 1;
		ap();
		watch(6);
		chk("load pulse", 1, seen[2]);
		chk("ref set", 1, reference_set_o);
		chk("load value", reference_coordinate_i, actual_load_value_o);
		$display("Test set reference done");
		c.teach_request_bit = 1;
		ap();
		watch(6);
		chk("teach rise", 0, seen[4]);
		teach_done_i = 1;
		tick();
		teach_done_i = 0;
		watch(2);
		chk("teach ok", 1, teach_ok_o);
		c.teach_request_bit = 0;
		ap();
		watch(6);
		chk("teach write", 1, seen[4]);
		chk("teach pos", axis_position_i, teach_position_o);
		chk("teach ok clr", 0, teach_ok_o);
		operating_mode_setting_i = 4'h2;
		c.teach_request_bit = 1;
		ap();
		c.teach_request_bit = 0;
		watch(3);
		ap();
		watch(6);
		chk("teach mode", 0, seen[4]);
		$display("Test teach done");
		c.homing_start_bit = 1;
		ap();
		watch(6);
		chk("homing", 1, homing_active_o);
		c.homing_start_bit = 0;
		ap();
		watch(6);
		chk("abort brake", 1, seen[1]);
		chk("abort ref", 0, reference_set_o);
		$display("Test homing done");
		block_running_i = 1; block_ext_cont_i = 1; block_flying_i = 1; brake_too_long_i = 1;
		s.slow_input_one = 1;
		ap();
		watch(6);
		chk("slow change", 1, nbc);
		chk("change pos", axis_position_i, block_change_position_o);
		chk("downgrade", 1, advance_with_stop_o);
		moving_positive_i = 0; c.ext_block_change_bit = 1;
		ap();
		watch(6);
		chk("bus change", 1, nbc);
		block_ext_cont_i = 0; s.slow_input_two = 1;
		ap();
		watch(6);
		chk("not external", 0, nbc);
		block_ext_cont_i = 1;
		moving_positive_i = 1; s.fast_is_ebc = 1;
		for (int k = 0; k < 4; k++)
		begin
			{actual_invert_a_i, actual_invert_b_i, actual_invert_c_i} = pat[k];
			s.fast_input_terminal = 1;
			ap();
			watch(6);
			chk("fast rise", ^pat[k], nbc);
			s.fast_input_terminal = 0;
			ap();
			watch(6);
			chk("fast fall", !(^pat[k]), nbc);
		end
		s.slow_input_one = 0; s.slow_input_two = 0; c.ext_block_change_bit = 0;
		ap();
		watch(6);
		chk("masked", 0, nbc);
		$display("Test block change done");
		c.fixed_stop_sensor_bit = 1;
		ap();
		watch(6);
		chk("fstop off", 0, fixed_stop_reached_o);
		fixed_stop_config_two_i = 1;
		watch(3);
		chk("fstop on", 1, fixed_stop_reached_o);
		$display("Test fixed stop done");
		block_running_i = 0; zero_mark_found_i = 1;
		pas();
		chk("passive move", 1, seen[0]);
		passive_homing_mode_i = 2'h0;
		pas();
		chk("passive set", 1, seen[2]);
		zero_mark_found_i = 0;
		pas();
		chk("passive fault", 1, passive_fault_o);
		$display("Test passive done");
		c.tracking_select_bit = 1; controller_enable_i = 0;
		ap();
		watch(6);
		chk("track on", 1, tracking_active_o);
		chk("no setpoint", 0, setpoint_enable_o);
		chk("error mask", 1, follow_error_mask_o);
		c.tracking_select_bit = 0; controller_enable_i = 1;
		ap();
		watch(6);
		chk("track off", 0, position_loop_open_o);
		error_tracking_i = 1;
		watch(2);
		chk("err track", 1, tracking_active_o);
		error_tracking_i = 0;
		$display("Test tracking done");
		wrap_up();
	end
endmodule : tb
`default_nettype wire
